// ===== hdl/dtbcs_ctrl_status.sv
// control and status register bank with burst control for a tone transceiver
// Functional notes
// [RULE_01] burst-off bit low means burst mode; high means burst mode off.
// [RULE_02] in burst mode a transmit data write starts equal burst and pause.
// [RULE_03] end of pause sets transmit-empty and raises interrupt when enabled.
// [RULE_04] call-progress mode doubles burst and pause to 102 ms.
// [RULE_05] burst off: tone follows tone-output enable bit, no timing.
// [RULE_06] test bit with DTMF mode: interrupt pin follows late steering flag.
// [RULE_07] single-tone bit high gives single tone, low gives dual tone.
// [RULE_08] column bit picks column tone over row, only in single tone.
// [RULE_09] status interrupt set with transmit-empty or receive-full, cleared by status read.
// [RULE_10] transmit-empty cleared by status read, held clear outside burst mode.
// [RULE_11] receive-full set on valid received digit, cleared by status read.
// [RULE_12] late steering set when tone absence validated, cleared on valid tone.
// [RULE_13] control writes go first register; select bit steers next one to second.
// [RULE_14] interrupt enabled in DTMF mode pulls pin low on digit or transmitter ready.
// [RULE_15] host uses select high for control/status, low for data registers.
// [RULE_16] burst and pause counted on the clock, doubled in call-progress mode.
`timescale 1ns/1ps
module dtbcs_ctrl_status
   import dtbcs_pkg::*;
#(
   parameter int P_BURST_CYCLES = BURST_CYCLES,
   parameter int P_CP_BURST_CYCLES = CP_BURST_CYCLES
) (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // host bus
   input wire logic i_cs_n,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic i_register_select_line,
   input wire logic [3:0] i_data,
   output logic [3:0] o_data,
   output logic o_data_oe,
   // receiver events
   input wire logic i_rx_valid,
   input wire logic [3:0] i_rx_code,
   input wire logic i_steer_absent,
   input wire logic i_steer_present,
   input wire logic i_cp_square,
   // transmitter control
   output logic o_tone_enable,
   output logic o_tone_single,
   output logic o_tone_column,
   output logic [3:0] o_tx_code,
   // open-drain interrupt / call-progress pin
   output logic o_interrupt_callprog_pin_o,
   output logic o_interrupt_callprog_pin_oe
);

   dtbcs_timer_if tmr_if ();

   dtbcs_burst_timer #(
      .P_BURST_CYCLES(P_BURST_CYCLES),
      .P_CP_BURST_CYCLES(P_CP_BURST_CYCLES)
   ) u_timer (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_clk_en(i_clk_en),
      .tmr(tmr_if.timer)
   );

   // bus strobe tracking
   logic wr_act, rd_act, wr_take, rd_end;
   logic wr_act_r, wr_act_nxt;
   logic rd_act_r, rd_act_nxt;
   logic rd_status_r, rd_status_nxt;

   // registers
   logic [3:0] control_reg_first_r, control_reg_first_nxt;
   logic [3:0] control_reg_second_r, control_reg_second_nxt;
   logic second_ctrl_select_r, second_ctrl_select_nxt;
   logic [3:0] status_r, status_nxt;
   logic [3:0] rx_data_r, rx_data_nxt;
   logic [3:0] tx_code_r, tx_code_nxt;

   // outputs
   logic [3:0] data_r, data_nxt;
   logic data_oe_r, data_oe_nxt;
   logic tone_en_r, tone_en_nxt;
   logic single_r, single_nxt;
   logic column_r, column_nxt;
   logic pin_oe_r, pin_oe_nxt;

   logic burst_mode, dtmf_mode, irq_enabled, tx_set, start;

   assign wr_act = !i_cs_n && !i_wr_n;
   assign rd_act = !i_cs_n && !i_rd_n;
   assign wr_take = wr_act && !wr_act_r;
   // interrupt, transmit-empty and receive-full flags clear once the status read strobe is released
   assign rd_end = rd_act_r && !rd_act && rd_status_r; // see [RULE_15]

   assign burst_mode = !control_reg_second_r[CRB_BURST_OFF]; // see [RULE_01]
   assign dtmf_mode = !control_reg_first_r[CRA_CALLPROG];
   assign irq_enabled = control_reg_first_r[CRA_IRQ_EN];
   assign tx_set = tmr_if.done && burst_mode;
   assign start = wr_take && !i_register_select_line && burst_mode; // see [RULE_02]

   assign tmr_if.start = start;
   assign tmr_if.long_mode = control_reg_first_r[CRA_CALLPROG]; // see [RULE_04]

   // bus and control registers
   always_comb begin
      wr_act_nxt = wr_act;
      rd_act_nxt = rd_act;
      rd_status_nxt = rd_status_r;
      control_reg_first_nxt = control_reg_first_r;
      control_reg_second_nxt = control_reg_second_r;
      second_ctrl_select_nxt = second_ctrl_select_r;
      tx_code_nxt = tx_code_r;
      if (rd_act && !rd_act_r) begin
         rd_status_nxt = i_register_select_line; // see [RULE_15]
      end
      if (wr_take) begin
         if (i_register_select_line) begin
            if (second_ctrl_select_r) begin
               control_reg_second_nxt = i_data; // see [RULE_13]
               second_ctrl_select_nxt = 1'b0;
            end else begin
               control_reg_first_nxt = i_data;
               second_ctrl_select_nxt = i_data[CRA_SEL_SECOND]; // see [RULE_13]
            end
         end else begin
            tx_code_nxt = i_data;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
         rd_status_r <= 1'b0;
         control_reg_first_r <= CRA_RESET;
         control_reg_second_r <= CRB_RESET;
         second_ctrl_select_r <= 1'b0;
         tx_code_r <= DATA_RESET;
      end else if (i_clk_en) begin
         wr_act_r <= wr_act_nxt;
         rd_act_r <= rd_act_nxt;
         rd_status_r <= rd_status_nxt;
         control_reg_first_r <= control_reg_first_nxt;
         control_reg_second_r <= control_reg_second_nxt;
         second_ctrl_select_r <= second_ctrl_select_nxt;
         tx_code_r <= tx_code_nxt;
      end
   end

   // status flags; a set in the clearing cycle wins
   always_comb begin
      status_nxt = status_r;
      rx_data_nxt = rx_data_r;
      if (i_rx_valid) begin
         rx_data_nxt = i_rx_code;
      end
      if (burst_mode) begin
         status_nxt[ST_TX_EMPTY] = tx_set || (status_r[ST_TX_EMPTY] && !rd_end); // see [RULE_10] [RULE_03]
      end else begin
         status_nxt[ST_TX_EMPTY] = 1'b0; // see [RULE_10]
      end
      status_nxt[ST_RX_FULL] = i_rx_valid || (status_r[ST_RX_FULL] && !rd_end); // see [RULE_11]
      status_nxt[ST_IRQ] = tx_set || i_rx_valid || (status_r[ST_IRQ] && !rd_end); // see [RULE_09]
      if (i_steer_absent) begin
         status_nxt[ST_LATE_STEER] = 1'b1; // see [RULE_12]
      end else if (i_steer_present) begin
         status_nxt[ST_LATE_STEER] = 1'b0; // see [RULE_12]
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         status_r <= STATUS_RESET;
         rx_data_r <= DATA_RESET;
      end else if (i_clk_en) begin
         status_r <= status_nxt;
         rx_data_r <= rx_data_nxt;
      end
   end

   // output drive
   always_comb begin
      data_oe_nxt = rd_act;
      data_nxt = DATA_RESET;
      if (rd_act) begin
         data_nxt = i_register_select_line ? status_r : rx_data_r; // see [RULE_15]
      end
      if (burst_mode) begin
         tone_en_nxt = control_reg_first_r[CRA_TONE_OUT] && tmr_if.tone_on; // see [RULE_02]
      end else begin
         tone_en_nxt = control_reg_first_r[CRA_TONE_OUT]; // see [RULE_05]
      end
      single_nxt = control_reg_second_r[CRB_SINGLE]; // see [RULE_07]
      column_nxt = control_reg_second_r[CRB_SINGLE] && control_reg_second_r[CRB_COLUMN]; // see [RULE_08]
      // pin is pulled low while enable is high
      if (control_reg_second_r[CRB_TEST] && dtmf_mode) begin
         pin_oe_nxt = !status_r[ST_LATE_STEER]; // see [RULE_06]
      end else if (irq_enabled && !dtmf_mode) begin
         pin_oe_nxt = !i_cp_square;
      end else if (irq_enabled) begin
         pin_oe_nxt = status_r[ST_IRQ]; // see [RULE_14] [RULE_03]
      end else begin
         pin_oe_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         data_r <= DATA_RESET;
         data_oe_r <= 1'b0;
         tone_en_r <= 1'b0;
         single_r <= 1'b0;
         column_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end else if (i_clk_en) begin
         data_r <= data_nxt;
         data_oe_r <= data_oe_nxt;
         tone_en_r <= tone_en_nxt;
         single_r <= single_nxt;
         column_r <= column_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign o_data = data_r;
   assign o_data_oe = data_oe_r;
   assign o_tone_enable = tone_en_r;
   assign o_tone_single = single_r;
   assign o_tone_column = column_r;
   assign o_tx_code = tx_code_r;
   assign o_interrupt_callprog_pin_o = 1'b0;
   assign o_interrupt_callprog_pin_oe = pin_oe_r;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n || !i_clk_en);

   sequence s_select_second;
      wr_take && i_register_select_line && !second_ctrl_select_r && i_data[CRA_SEL_SECOND];
   endsequence

   sequence s_second_write;
      wr_take && i_register_select_line && second_ctrl_select_r;
   endsequence

   sequence s_first_write;
      wr_take && i_register_select_line && !second_ctrl_select_r;
   endsequence

   a_select_arm: assert property (s_select_second |=> second_ctrl_select_r) // see [RULE_13]
      else $error("second control select not armed");
   a_second_write: assert property (s_second_write |=> control_reg_second_r == $past(i_data)
         && !second_ctrl_select_r && control_reg_first_r == $past(control_reg_first_r)) // see [RULE_13]
      else $error("control write not steered to second register");
   a_burst_off_tx: assert property (!burst_mode |=> !status_r[ST_TX_EMPTY]) // see [RULE_10]
      else $error("transmit empty set outside burst mode");
   a_tx_ready_set: assert property (tx_set |=> status_r[ST_TX_EMPTY] && status_r[ST_IRQ]) // see [RULE_03]
      else $error("end of pause did not set transmit empty");
   a_rx_full_set: assert property (i_rx_valid |=> status_r[ST_RX_FULL] && status_r[ST_IRQ]
         && rx_data_r == $past(i_rx_code)) // see [RULE_11]
      else $error("received digit not flagged");
   a_read_clear: assert property (rd_end && !tx_set && !i_rx_valid |=> !status_r[ST_IRQ]
         && !status_r[ST_RX_FULL] && !status_r[ST_TX_EMPTY]) // see [RULE_09]
      else $error("status read did not clear flags");
   a_late_steer: assert property (i_steer_absent |=> status_r[ST_LATE_STEER]) // see [RULE_12]
      else $error("late steering flag not set");
   a_steer_clear: assert property (i_steer_present && !i_steer_absent |=> !status_r[ST_LATE_STEER]) // see [RULE_12]
      else $error("late steering flag not cleared");
   a_tone_free: assert property (!burst_mode |=> o_tone_enable == $past(control_reg_first_r[CRA_TONE_OUT])) // see [RULE_05]
      else $error("tone output not following enable bit");
   a_test_pin: assert property (control_reg_second_r[CRB_TEST] && dtmf_mode
         |=> o_interrupt_callprog_pin_oe == !$past(status_r[ST_LATE_STEER])) // see [RULE_06]
      else $error("pin not following late steering flag");
   a_irq_pin: assert property (irq_enabled && dtmf_mode && !control_reg_second_r[CRB_TEST]
         |=> o_interrupt_callprog_pin_oe == $past(status_r[ST_IRQ])) // see [RULE_14]
      else $error("interrupt pin not following interrupt flag");
   a_column_gate: assert property (!control_reg_second_r[CRB_SINGLE] |=> !o_tone_column) // see [RULE_08]
      else $error("column select active in dual tone");
   a_burst_start: assert property (start && u_timer.state_r == TMR_IDLE |=> ##[1:2] (tmr_if.tone_on)) // see [RULE_02]
      else $error("burst not started by transmit write");
   a_first_write: assert property (s_first_write |=> control_reg_first_r == $past(i_data)) // see [RULE_13]
      else $error("control write not stored in first register");
   a_first_keep: assert property (s_first_write // see [RULE_13]
         |=> control_reg_second_r == $past(control_reg_second_r))
      else $error("second register changed by first register write");
   a_tx_write: assert property (wr_take && !i_register_select_line // see [RULE_02]
         |=> o_tx_code == $past(i_data))
      else $error("transmit code not stored");
   a_tone_burst: assert property (burst_mode // see [RULE_02]
         |=> o_tone_enable == $past(control_reg_first_r[CRA_TONE_OUT] && tmr_if.tone_on))
      else $error("burst tone not gated by timer");
   a_single_sel: assert property (1'b1 // see [RULE_07]
         |=> o_tone_single == $past(control_reg_second_r[CRB_SINGLE]))
      else $error("single tone output not following select bit");
   a_column_sel: assert property (control_reg_second_r[CRB_SINGLE] // see [RULE_08]
         |=> o_tone_column == $past(control_reg_second_r[CRB_COLUMN]))
      else $error("column output not following select bit");
   a_cp_pin: assert property (irq_enabled && !dtmf_mode // see [RULE_14]
         |=> o_interrupt_callprog_pin_oe == !$past(i_cp_square))
      else $error("pin not following call progress input");
   a_pin_quiet: assert property (!irq_enabled && !(control_reg_second_r[CRB_TEST] && dtmf_mode) // see [RULE_14]
         |=> !o_interrupt_callprog_pin_oe)
      else $error("pin pulled low with interrupt off");
   a_read_data: assert property (rd_act && i_register_select_line // see [RULE_09]
         |=> o_data == $past(status_r) && o_data_oe)
      else $error("status not presented on read");
   a_rx_hold: assert property (!i_rx_valid && !rd_end // see [RULE_11]
         |=> status_r[ST_RX_FULL] == $past(status_r[ST_RX_FULL]))
      else $error("receive full changed without cause");

endmodule : dtbcs_ctrl_status

// ===== hdl/dtbcs_pkg.sv
// constants, field positions and types for the tone burst control and status block
package dtbcs_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BURST_TIME_MS = 51;
   localparam int CP_BURST_TIME_MS = 102;
   localparam int BURST_CYCLES = BURST_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CP_BURST_CYCLES = CP_BURST_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TMR_W = 24;

   // first control register fields
   localparam int CRA_TONE_OUT = 0;
   localparam int CRA_CALLPROG = 1;
   localparam int CRA_IRQ_EN = 2;
   localparam int CRA_SEL_SECOND = 3;

   // second control register fields
   localparam int CRB_BURST_OFF = 0;
   localparam int CRB_TEST = 1;
   localparam int CRB_SINGLE = 2;
   localparam int CRB_COLUMN = 3;

   // status register fields
   localparam int ST_IRQ = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_LATE_STEER = 3;

   // reset values
   localparam logic [3:0] CRA_RESET = 4'h0;
   localparam logic [3:0] CRB_RESET = 4'h0;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam logic [3:0] DATA_RESET = 4'h0;

   typedef enum logic [2:0] {
      TMR_IDLE = 3'b001,
      TMR_TONE = 3'b010,
      TMR_PAUSE = 3'b100
   } dtbcs_tmr_state_t;

endpackage : dtbcs_pkg

// ===== hdl/dtbcs_timer_if.sv
// link between the register bank and the burst timer
`timescale 1ns/1ps
interface dtbcs_timer_if;
   logic start;
   logic long_mode;
   logic tone_on;
   logic done;

   modport ctrl (output start, output long_mode, input tone_on, input done);
   modport timer (input start, input long_mode, output tone_on, output done);
endinterface : dtbcs_timer_if

// ===== hdl/dtbcs_burst_timer.sv
// burst and pause timer
`timescale 1ns/1ps
module dtbcs_burst_timer
   import dtbcs_pkg::*;
#(
   parameter int P_BURST_CYCLES = BURST_CYCLES,
   parameter int P_CP_BURST_CYCLES = CP_BURST_CYCLES
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // control side
   dtbcs_timer_if.timer tmr
);

   dtbcs_tmr_state_t state_r, state_nxt;
   logic [TMR_W-1:0] cnt_r, cnt_nxt;
   logic done_r, done_nxt;
   logic [TMR_W-1:0] last_cnt;

   // call-progress mode doubles burst and pause
   assign last_cnt = tmr.long_mode ? TMR_W'(P_CP_BURST_CYCLES - 1) : TMR_W'(P_BURST_CYCLES - 1); // see [RULE_04] [RULE_16]

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      unique case (state_r)
         TMR_IDLE: begin
            if (tmr.start) begin // see [RULE_02]
               state_nxt = TMR_TONE;
               cnt_nxt = '0;
            end
         end
         TMR_TONE: begin
            if (cnt_r >= last_cnt) begin
               state_nxt = TMR_PAUSE;
               cnt_nxt = '0;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         TMR_PAUSE: begin
            if (cnt_r >= last_cnt) begin
               state_nxt = TMR_IDLE;
               cnt_nxt = '0;
               done_nxt = 1'b1; // see [RULE_03]
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = TMR_IDLE;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= TMR_IDLE;
         cnt_r <= '0;
         done_r <= 1'b0;
      end else if (i_clk_en) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign tmr.tone_on = (state_r == TMR_TONE);
   assign tmr.done = done_r;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n || !i_clk_en);

   sequence s_idle_start;
      state_r == TMR_IDLE && tmr.start;
   endsequence

   a_burst_start: assert property (s_idle_start |=> state_r == TMR_TONE && cnt_r == '0) // see [RULE_02]
      else $error("burst did not start on request");
   a_pause_done: assert property (done_r |-> $past(state_r) == TMR_PAUSE && state_r == TMR_IDLE) // see [RULE_03]
      else $error("done raised outside end of pause");
   a_count_bound: assert property (state_r != TMR_IDLE |-> cnt_r <= TMR_W'(P_CP_BURST_CYCLES - 1)) // see [RULE_16]
      else $error("timer count ran past longest duration");

endmodule : dtbcs_burst_timer

// ===== bench/dtbcs_host_model.sv
// host bus model that drives the control and status block like a microcontroller
`timescale 1ns/1ps
module dtbcs_host_model (
   // clock and read data
   input wire logic i_clk_sys,
   input wire logic [3:0] i_data,
   // host strobes and write data
   output logic o_cs_n,
   output logic o_wr_n,
   output logic o_rd_n,
   output logic o_sel,
   output logic [3:0] o_data
);
   initial begin
      o_cs_n = 1'b1;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_sel = 1'b0;
      o_data = 4'h0;
   end

   // select high reaches control/status, low the data registers
   task automatic bus_write(input logic sel, input logic [3:0] d);
      @(posedge i_clk_sys);
      o_cs_n <= 1'b0;
      o_wr_n <= 1'b0;
      o_sel <= sel;
      o_data <= d;
      @(posedge i_clk_sys);
      @(posedge i_clk_sys);
      o_cs_n <= 1'b1;
      o_wr_n <= 1'b1;
      // released bus shows no stale value
      o_data <= ~d;
      @(posedge i_clk_sys);
   endtask : bus_write

   // data taken at the edge where the strobe is released
   task automatic bus_read(input logic sel, output logic [3:0] d);
      @(posedge i_clk_sys);
      o_cs_n <= 1'b0;
      o_rd_n <= 1'b0;
      o_sel <= sel;
      @(posedge i_clk_sys);
      @(posedge i_clk_sys);
      d = i_data;
      o_cs_n <= 1'b1;
      o_rd_n <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
   endtask : bus_read
endmodule : dtbcs_host_model

// ===== bench/dtbcs_ctrl_status_test.sv
// self-checking testbench for the tone burst control and status block
`timescale 1ns/1ps
module dtbcs_ctrl_status_test;
   import dtbcs_pkg::*;
   localparam int P_BURST = 20;
   localparam int P_CP = 40;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cs_n, wr_n, rd_n, sel;
   logic [3:0] wdata, rdata, tx_code, rx_code = 4'h0;
   logic data_oe, tone_en, tone_single, tone_column, pin_o, pin_oe;
   logic rx_valid = 1'b0, steer_absent = 1'b0, steer_present = 1'b0, cp_square = 1'b0;
   logic clk_en = 1'b1;
   logic rd_seen = 1'b0;
   int tone_run = 0;
   int tone_last = 0;
   logic [3:0] v;
   logic [3:0] crb_tab [4] = '{4'h1, 4'h5, 4'h9, 4'hd};
   int n_mismatch = 0;
   int checked = 0;
   int n;

   always #5 clk = ~clk;

   dtbcs_host_model host (.i_clk_sys(clk), .i_data(rdata), .o_cs_n(cs_n), .o_wr_n(wr_n),
      .o_rd_n(rd_n), .o_sel(sel), .o_data(wdata));

   dtbcs_ctrl_status #(.P_BURST_CYCLES(P_BURST), .P_CP_BURST_CYCLES(P_CP)) DUT (
      .i_clk_sys(clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
      .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_register_select_line(sel),
      .i_data(wdata), .o_data(rdata), .o_data_oe(data_oe),
      .i_rx_valid(rx_valid), .i_rx_code(rx_code), .i_steer_absent(steer_absent),
      .i_steer_present(steer_present), .i_cp_square(cp_square),
      .o_tone_enable(tone_en), .o_tone_single(tone_single), .o_tone_column(tone_column),
      .o_tx_code(tx_code), .o_interrupt_callprog_pin_o(pin_o),
      .o_interrupt_callprog_pin_oe(pin_oe));

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_status(input logic [3:0] exp);
      logic [3:0] d;
      host.bus_read(1'b1, d);
      chk(d, exp);
   endtask : rd_status

   // length of the next tone burst in cycles
   task automatic tone_len(output int len);
      int k;
      for (k = 0; k < 100 && tone_en !== 1'b1; k++) tick(1);
      for (k = 0; k < 200 && tone_en === 1'b1; k++) tick(1);
      tick(1);
      len = tone_last;
   endtask : tone_len

   // run length of each tone burst, sampled at every edge
   always @(posedge clk) begin
      if (tone_en === 1'b1) begin
         tone_run <= tone_run + 1;
      end else begin
         if (tone_run != 0) begin
            tone_last <= tone_run;
         end
         tone_run <= 0;
      end
   end

   // data bus drive trails the read strobe by one cycle
   always @(posedge clk) begin
      rd_seen <= !cs_n && !rd_n;
      if (reset_n === 1'b1) begin
         chk(data_oe, rd_seen);
      end
   end

   task automatic end_of_test();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      tick(2);
      chk(pin_oe, 1'b0);
      chk(pin_o, 1'b0);
      chk(rdata, 4'h0);
      rd_status(STATUS_RESET);
      // burst mode, DTMF, interrupt on
      host.bus_write(1'b1, 4'hd);
      host.bus_write(1'b1, 4'h0);
      host.bus_write(1'b0, 4'h7);
      chk(tx_code, 4'h7);
      chk(tone_single, 1'b0);
      tone_len(n);
      chk(n, P_BURST);
      tick(18);
      chk(pin_oe, 1'b0);
      tick(5);
      chk(pin_oe, 1'b1);
      rd_status(4'h3);
      tick(2);
      chk(pin_oe, 1'b0);
      rd_status(4'h0);
      // call-progress mode doubles both spans
      host.bus_write(1'b1, 4'h7);
      host.bus_write(1'b0, 4'h3);
      tone_len(n);
      chk(n, P_CP);
      @(posedge clk);
      cp_square <= 1'b1;
      tick(3);
      chk(pin_oe, 1'b0);
      @(posedge clk);
      cp_square <= 1'b0;
      tick(3);
      chk(pin_oe, 1'b1);
      tick(45);
      rd_status(4'h3);
      // burst off with each tone selection
      for (int i = 0; i < 4; i++) begin
         host.bus_write(1'b1, 4'h9);
         host.bus_write(1'b1, crb_tab[i]);
         tick(2);
         chk(tone_single, crb_tab[i][2]);
         chk(tone_column, crb_tab[i][2] & crb_tab[i][3]);
         chk(tone_en, 1'b1);
      end
      host.bus_write(1'b1, 4'h0);
      tick(2);
      chk(tone_en, 1'b0);
      host.bus_write(1'b0, 4'h5);
      tick(60);
      chk(tone_en, 1'b0);
      rd_status(4'h0);
      // test mode: pin follows the late steering flag
      host.bus_write(1'b1, 4'h8);
      host.bus_write(1'b1, 4'h2);
      tick(2);
      chk(pin_oe, 1'b1);
      @(posedge clk);
      steer_absent <= 1'b1;
      @(posedge clk);
      steer_absent <= 1'b0;
      tick(3);
      chk(pin_oe, 1'b0);
      rd_status(4'h8);
      @(posedge clk);
      steer_present <= 1'b1;
      @(posedge clk);
      steer_present <= 1'b0;
      tick(3);
      chk(pin_oe, 1'b1);
      rd_status(4'h0);
      // received digit
      @(posedge clk);
      rx_code <= 4'ha;
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
      tick(2);
      rd_status(4'h5);
      host.bus_read(1'b0, v);
      chk(v, 4'ha);
      rd_status(4'h0);
      // frozen clock enable: a write is not taken
      @(posedge clk);
      clk_en <= 1'b0;
      host.bus_write(1'b0, 4'hc);
      tick(2);
      chk(tx_code, 4'h5);
      @(posedge clk);
      clk_en <= 1'b1;
      host.bus_write(1'b0, 4'h6);
      chk(tx_code, 4'h6);
      end_of_test();
   end
endmodule : dtbcs_ctrl_status_test
